// ### rtl/phy_status_pkg.sv
// Constants shared by the next page transmit and summary status register logic
package phy_status_pkg;

  // ---------------------------------------------------------------
  // Register addresses on the management port
  // ---------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int CODE_W = 11;
  localparam logic [4:0] ADR_AUTONEG_EXP = 5'h06;
  localparam logic [4:0] ADR_NEXT_PAGE_TX = 5'h07;
  localparam logic [4:0] ADR_SUMMARY_STATUS = 5'h10;
  localparam logic [4:0] ADR_FALSE_CARRIER_CNT = 5'h14;
  localparam logic [4:0] ADR_RX_ERROR_CNT = 5'h15;
  localparam logic [4:0] ADR_TENBASE_STATUS = 5'h1A;
  localparam logic [4:0] ADR_IRQ_STATUS = 5'h1B;
  localparam logic [4:0] ADR_IRQ_MASK = 5'h1C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int NPT_REQ_BIT = 15;
  localparam int NPT_MSG_BIT = 13;
  localparam int NPT_ACK_BIT = 12;
  localparam int NPT_TOG_BIT = 11;
  localparam int STS_RXERR_BIT = 13;
  localparam int STS_POL_BIT = 12;
  localparam int STS_FC_BIT = 11;
  localparam int STS_SD_BIT = 10;
  localparam int STS_LOCK_BIT = 9;
  localparam int STS_PAGE_BIT = 8;
  localparam int EXP_ABLE_BIT = 2;
  localparam int EXP_PAGE_BIT = 1;
  localparam int TEN_POL_BIT = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [10:0] CODE_RST = 11'h001;
  localparam logic MSG_RST = 1'b1;
  localparam logic REQ_RST = 1'b0;
  localparam logic ACK_RST = 1'b0;
  localparam logic TOG_RST = 1'b0;
  localparam logic EXP_ABLE_VAL = 1'b1;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // ---------------------------------------------------------------
  // Sticky flag indices: four status latches, then interrupt bits
  // ---------------------------------------------------------------
  localparam int FLAGS = 9;
  localparam int F_RXERR = 0;
  localparam int F_FC = 1;
  localparam int F_POL = 2;
  localparam int F_PAGE = 3;
  localparam int F_IRQ0 = 4;
  localparam int IRQ_W = 5;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;

endpackage

// ### rtl/event_latch.sv
// Sticky flag whose set beats a clear in the same cycle
`timescale 1ns/1ps
module event_latch (
  input wire logic clk_in, // Clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic set_in, // Event
  input wire logic clr_in, // Clear request
  output logic q_out // Flag
);

  // Set has priority so an event in the clearing cycle survives
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q_out <= 1'b0;
    end else if (set_in) begin
      q_out <= 1'b1;
    end else if (clr_in) begin
      q_out <= 1'b0;
    end
  end

endmodule // event_latch

// ### rtl/latch_low.sv
// Latched-low status bit refreshed from its live source on a read
`timescale 1ns/1ps
module latch_low (
  input wire logic clk_in, // Clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic live_in, // Live source level
  input wire logic rd_in, // Status register read
  output logic q_out // Latched value
);

  logic q_nxt;

  // A drop sticks until read; a read reloads the live level
  assign q_nxt = rd_in ? live_in : (q_out & live_in);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q_out <= 1'b0;
    end else begin
      q_out <= q_nxt;
    end
  end

endmodule // latch_low

// ### rtl/next_page_status_regs.sv
// Next page transmit register and upper summary status register bank
`timescale 1ns/1ps

// Functional notes
// (RULE_01) Summary status bits 15:14 ignore writes and read as zero.
// (RULE_02) Bit 12 of next page register is writable comply flag, reset zero.
// (RULE_03) Bit 11 is read-only, inverse of last exchanged word's toggle bit.
// (RULE_04) Bits 10:0 hold writable code field, reset to null page value.
// (RULE_05) Message page flag set means code is message, else unformatted.
// (RULE_06) Status bit 13 latches receive errors, clears on error counter read.
// (RULE_07) Status bit 12 copies polarity, clears on 10 Mb/s register read only.
// (RULE_08) Status bit 11 latches false carrier, clears on its counter read.
// (RULE_09) Status bit 10 is latched-low signal detect, read-only, reset zero.
// (RULE_10) Status bit 9 is latched-low descrambler lock, read-only, reset zero.
// (RULE_11) Status bit 8 copies page received, cleared only by expansion read.
// (RULE_12) Expansion bit 1 sets on received code word, clears on read.
// (RULE_13) Bit 15 is writable request for another next page.
// (RULE_14) Latched-low bit holds zero until read, then shows live value.
module next_page_status_regs
  import phy_status_pkg::*;
(
  input wire logic CLOCK_IN, // 200 MHz clock
  input wire logic ARST_N_IN, // Async reset, active low
  input wire logic [4:0] ADDR_IN, // Register address
  input wire logic [15:0] WDATA_IN, // Write data
  input wire logic WR_IN, // Write strobe
  input wire logic RD_IN, // Read strobe
  output logic [15:0] RDATA_OUT, // Read data, cycle after strobe
  input wire logic RX_ERR_IN, // Receive error event pulse
  input wire logic FALSE_CARRIER_IN, // False carrier event pulse
  input wire logic POLARITY_INV_IN, // Inverted polarity level
  input wire logic SIGNAL_DETECT_IN, // Live signal detect
  input wire logic DESCR_LOCK_IN, // Live descrambler lock
  input wire logic LCW_RX_IN, // Link code word exchanged pulse
  input wire logic LCW_TOGGLE_IN, // Toggle bit of that word
  output logic NEXT_PAGE_REQUEST_OUT, // Another next page wanted
  output logic MESSAGE_PAGE_FLAG_OUT, // Code is a message page
  output logic COMPLY_ACKNOWLEDGE_OUT, // Will comply with message
  output logic TOGGLE_OUT, // Toggle for next transmit word
  output logic [10:0] CODE_OUT, // Code field to transmit
  output logic IRQ_OUT // Interrupt, active high level
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic wr_npt;
  logic wr_mask;
  logic rd_exp;
  logic rd_npt;
  logic rd_sum;
  logic rd_fc;
  logic rd_rxe;
  logic rd_ten;
  logic rd_irq;
  logic rd_mask;

  // One read strobe per register address; write strobes for next page and mask only
  assign wr_npt = WR_IN && (ADDR_IN == ADR_NEXT_PAGE_TX);
  assign wr_mask = WR_IN && (ADDR_IN == ADR_IRQ_MASK);
  assign rd_exp = RD_IN && (ADDR_IN == ADR_AUTONEG_EXP);
  assign rd_npt = RD_IN && (ADDR_IN == ADR_NEXT_PAGE_TX);
  assign rd_sum = RD_IN && (ADDR_IN == ADR_SUMMARY_STATUS);
  assign rd_fc = RD_IN && (ADDR_IN == ADR_FALSE_CARRIER_CNT);
  assign rd_rxe = RD_IN && (ADDR_IN == ADR_RX_ERROR_CNT);
  assign rd_ten = RD_IN && (ADDR_IN == ADR_TENBASE_STATUS);
  assign rd_irq = RD_IN && (ADDR_IN == ADR_IRQ_STATUS);
  assign rd_mask = RD_IN && (ADDR_IN == ADR_IRQ_MASK);

  // ---------------------------------------------------------------
  // Next page transmit register
  // ---------------------------------------------------------------
  logic req_r;
  logic msg_r;
  logic ack_r;
  logic tog_r;
  logic [10:0] code_r;

  // Software fields; bit 14 and bit 11 take no write
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      req_r <= REQ_RST;
      msg_r <= MSG_RST;
      ack_r <= ACK_RST;
      code_r <= CODE_RST; // see (RULE_04)
    end else if (wr_npt) begin
      req_r <= WDATA_IN[NPT_REQ_BIT]; // see (RULE_13)
      msg_r <= WDATA_IN[NPT_MSG_BIT];
      ack_r <= WDATA_IN[NPT_ACK_BIT]; // see (RULE_02)
      code_r <= WDATA_IN[CODE_W-1:0]; // see (RULE_04)
    end
  end

  // Toggle follows the inverse of each exchanged word's toggle
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tog_r <= TOG_RST;
    end else if (LCW_RX_IN) begin
      tog_r <= !LCW_TOGGLE_IN; // see (RULE_03)
    end
  end

  // Fields go out to the arbitration logic straight from the flops
  assign NEXT_PAGE_REQUEST_OUT = req_r;
  assign MESSAGE_PAGE_FLAG_OUT = msg_r; // see (RULE_05)
  assign COMPLY_ACKNOWLEDGE_OUT = ack_r;
  assign TOGGLE_OUT = tog_r;
  assign CODE_OUT = code_r; // see (RULE_05)

  // ---------------------------------------------------------------
  // Sticky flags: status latches and interrupt status
  // ---------------------------------------------------------------
  logic [FLAGS-1:0] set_vec;
  logic [FLAGS-1:0] clr_vec;
  logic [FLAGS-1:0] flag_q;
  logic sd_q;
  logic lock_q;
  logic sd_d1_r;
  logic lock_d1_r;
  logic [4:0] irq_ev;
  logic [4:0] irq_stat;
  logic [4:0] irq_mask_r;

  // Loss of signal or lock is an interrupt event
  assign irq_ev[0] = RX_ERR_IN;
  assign irq_ev[1] = FALSE_CARRIER_IN;
  assign irq_ev[2] = LCW_RX_IN;
  assign irq_ev[3] = sd_d1_r && !SIGNAL_DETECT_IN;
  assign irq_ev[4] = lock_d1_r && !DESCR_LOCK_IN;

  // Set and clear sources of each latch
  assign set_vec[F_RXERR] = RX_ERR_IN; // see (RULE_06)
  assign clr_vec[F_RXERR] = rd_rxe; // see (RULE_06)
  assign set_vec[F_FC] = FALSE_CARRIER_IN; // see (RULE_08)
  assign clr_vec[F_FC] = rd_fc; // see (RULE_08)
  assign set_vec[F_POL] = POLARITY_INV_IN; // see (RULE_07)
  assign clr_vec[F_POL] = rd_ten; // see (RULE_07)
  assign set_vec[F_PAGE] = LCW_RX_IN; // see (RULE_12)
  assign clr_vec[F_PAGE] = rd_exp; // see (RULE_11)
  assign set_vec[FLAGS-1:F_IRQ0] = irq_ev;
  assign clr_vec[FLAGS-1:F_IRQ0] = {IRQ_W{rd_irq}};

  // One sticky flag per status latch and per interrupt bit, nine in all
  genvar gi;
  generate
    for (gi = 0; gi < FLAGS; gi++) begin : g_flag
      event_latch u_flag (
        .clk_in(CLOCK_IN),
        .arst_n_in(ARST_N_IN),
        .set_in(set_vec[gi]),
        .clr_in(clr_vec[gi]),
        .q_out(flag_q[gi])
      );
    end
  endgenerate

  assign irq_stat = flag_q[FLAGS-1:F_IRQ0];

  // Latched-low signal detect and lock, refreshed by a status read
  latch_low u_sd (
    .clk_in(CLOCK_IN),
    .arst_n_in(ARST_N_IN),
    .live_in(SIGNAL_DETECT_IN), // see (RULE_09)
    .rd_in(rd_sum), // see (RULE_14)
    .q_out(sd_q)
  );

  latch_low u_lock (
    .clk_in(CLOCK_IN),
    .arst_n_in(ARST_N_IN),
    .live_in(DESCR_LOCK_IN), // see (RULE_10)
    .rd_in(rd_sum), // see (RULE_14)
    .q_out(lock_q)
  );

  // Previous live levels for the loss events, and the mask
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sd_d1_r <= 1'b0;
      lock_d1_r <= 1'b0;
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      sd_d1_r <= SIGNAL_DETECT_IN;
      lock_d1_r <= DESCR_LOCK_IN;
      if (wr_mask) begin
        irq_mask_r <= WDATA_IN[IRQ_W-1:0];
      end
    end
  end

  // Interrupt high while any unmasked status bit is set
  assign IRQ_OUT = |(irq_stat & irq_mask_r);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [15:0] npt_word;
  logic [15:0] sum_word;
  logic [15:0] exp_word;
  logic [15:0] ten_word;
  logic [15:0] rdata_nxt;
  logic [15:0] rdata_r;

  // Register images; unlisted bits read zero
  always_comb begin
    npt_word = ZERO16;
    npt_word[NPT_REQ_BIT] = req_r;
    npt_word[NPT_MSG_BIT] = msg_r;
    npt_word[NPT_ACK_BIT] = ack_r;
    npt_word[NPT_TOG_BIT] = tog_r; // see (RULE_03)
    npt_word[CODE_W-1:0] = code_r;
    sum_word = ZERO16; // see (RULE_01)
    sum_word[STS_RXERR_BIT] = flag_q[F_RXERR];
    sum_word[STS_POL_BIT] = flag_q[F_POL];
    sum_word[STS_FC_BIT] = flag_q[F_FC];
    sum_word[STS_SD_BIT] = sd_q;
    sum_word[STS_LOCK_BIT] = lock_q;
    sum_word[STS_PAGE_BIT] = flag_q[F_PAGE]; // see (RULE_11)
    exp_word = ZERO16;
    exp_word[EXP_ABLE_BIT] = EXP_ABLE_VAL;
    exp_word[EXP_PAGE_BIT] = flag_q[F_PAGE]; // see (RULE_12)
    ten_word = ZERO16;
    ten_word[TEN_POL_BIT] = flag_q[F_POL];
  end

  // Read selection; unmapped addresses answer zero
  assign rdata_nxt = rd_npt ? npt_word :
                     rd_sum ? sum_word :
                     rd_exp ? exp_word :
                     rd_ten ? ten_word :
                     rd_irq ? {11'h000, irq_stat} :
                     rd_mask ? {11'h000, irq_mask_r} :
                     ZERO16;

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rdata_r <= ZERO16;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA_OUT = rdata_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  // Reserved status bits read zero even after a write attempt
  property p_rsvd_zero;
    rd_sum |=> (RDATA_OUT[15:14] == 2'b00);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // see (RULE_01)
    else $error("reserved status bits not zero");

  // Comply flag takes the written bit
  property p_ack_write;
    wr_npt |=> (COMPLY_ACKNOWLEDGE_OUT == $past(WDATA_IN[NPT_ACK_BIT]));
  endproperty
  a_ack_write: assert property (p_ack_write) // see (RULE_02)
    else $error("comply flag not written");

  // Toggle is the inverse of the exchanged word's toggle
  property p_toggle;
    LCW_RX_IN |=> (TOGGLE_OUT == !$past(LCW_TOGGLE_IN));
  endproperty
  a_toggle: assert property (p_toggle) // see (RULE_03)
    else $error("toggle not inverted");

  // Toggle ignores writes
  property p_toggle_ro;
    (wr_npt && !LCW_RX_IN) |=> $stable(TOGGLE_OUT);
  endproperty
  a_toggle_ro: assert property (p_toggle_ro) // see (RULE_03)
    else $error("toggle changed by write");

  // Code field and message flag outputs follow a write
  property p_code_write;
    wr_npt |=> (CODE_OUT == $past(WDATA_IN[CODE_W-1:0]))
      && (MESSAGE_PAGE_FLAG_OUT == $past(WDATA_IN[NPT_MSG_BIT]));
  endproperty
  a_code_write: assert property (p_code_write) // see (RULE_04)
    else $error("code field not written");

  // Next page request follows a write
  property p_req_write;
    wr_npt |=> (NEXT_PAGE_REQUEST_OUT == $past(WDATA_IN[NPT_REQ_BIT]));
  endproperty
  a_req_write: assert property (p_req_write) // see (RULE_13)
    else $error("next page request not written");

  // Receive error shows in a status read strobed the next cycle
  property p_rxerr_seen;
    (RX_ERR_IN ##1 rd_sum) |=> RDATA_OUT[STS_RXERR_BIT];
  endproperty
  a_rxerr_seen: assert property (p_rxerr_seen) // see (RULE_06)
    else $error("receive error not latched");

  // Counter read clears the receive error latch
  property p_rxerr_clr;
    (rd_rxe && !RX_ERR_IN) |=> !flag_q[F_RXERR];
  endproperty
  a_rxerr_clr: assert property (p_rxerr_clr) // see (RULE_06)
    else $error("receive error latch not cleared");

  // Summary read leaves polarity alone
  property p_pol_keep;
    (flag_q[F_POL] && rd_sum) |=> flag_q[F_POL];
  endproperty
  a_pol_keep: assert property (p_pol_keep) // see (RULE_07)
    else $error("polarity cleared by summary read");

  // False carrier sets its latch, counter read clears it
  property p_fc;
    (FALSE_CARRIER_IN |=> flag_q[F_FC])
      and ((rd_fc && !FALSE_CARRIER_IN) |=> !flag_q[F_FC]);
  endproperty
  a_fc: assert property (p_fc) // see (RULE_08)
    else $error("false carrier latch wrong");

  // Dropped signal detect stays low until a status read
  property p_sd_hold;
    (!SIGNAL_DETECT_IN && !rd_sum) |=> !sd_q;
  endproperty
  a_sd_hold: assert property (p_sd_hold) // see (RULE_09)
    else $error("signal detect not latched low");

  // Lock reads live level after a status read
  property p_lock_reload;
    rd_sum |=> (lock_q == $past(DESCR_LOCK_IN));
  endproperty
  a_lock_reload: assert property (p_lock_reload) // see (RULE_14)
    else $error("lock not reloaded on read");

  // Page received survives a summary read, clears on expansion read
  property p_page;
    ((LCW_RX_IN ##1 rd_sum) |=> flag_q[F_PAGE])
      and ((rd_exp && !LCW_RX_IN) |=> !flag_q[F_PAGE]);
  endproperty
  a_page: assert property (p_page) // see (RULE_11)
    else $error("page received flag wrong");

  // Unmasked receive error raises the interrupt
  property p_irq;
    (RX_ERR_IN && irq_mask_r[0] && !wr_mask) |=> IRQ_OUT;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");

endmodule // next_page_status_regs

// ### test/mgmt_master.sv
// Management master model driving the register port of the status bank
`timescale 1ns/1ps
module mgmt_master (
  input wire logic clk_in, // Clock
  output logic [4:0] addr_out, // Register address
  output logic [15:0] wdata_out, // Write data
  output logic wr_out, // Write strobe
  output logic rd_out, // Read strobe
  input wire logic [15:0] rdata_in // Read data, cycle after strobe
);
  // ---------------------------------------------------------------
  // Idle levels at time zero
  // ---------------------------------------------------------------
  initial begin
    addr_out = 5'h00;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // One-cycle write; address and data are scrambled once the strobe drops
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
    #1;
  endtask

  // One-cycle read; data taken in the single cycle where it stands
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask
endmodule // mgmt_master

// ### test/next_page_status_regs_tb.sv
// Self-checking bench for the next page transmit and summary status bank
`timescale 1ns/1ps
module next_page_status_regs_tb
  import phy_status_pkg::*;
();
  logic clk, arst_n, wr, rd, sd, lock, lcw_tog, npr, msg, ack, tog, irq;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, d, last_d;
  logic [3:0] ev;
  logic [10:0] code;
  int fail_count, num_checks;
  logic [3:0] ev_tab [3] = '{4'h1, 4'h2, 4'h8};
  logic [4:0] clr_tab [3] = '{ADR_RX_ERROR_CNT, ADR_FALSE_CARRIER_CNT, ADR_TENBASE_STATUS};
  logic [15:0] bit_tab [3] = '{16'h2000, 16'h0800, 16'h1000};
  logic [15:0] clrv_tab [3] = '{16'h0000, 16'h0000, 16'h0010};

  // ---------------------------------------------------------------
  // Clock, design and management master
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  next_page_status_regs DUT (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RX_ERR_IN(ev[0]),
    .FALSE_CARRIER_IN(ev[1]), .POLARITY_INV_IN(ev[3]), .SIGNAL_DETECT_IN(sd),
    .DESCR_LOCK_IN(lock), .LCW_RX_IN(ev[2]), .LCW_TOGGLE_IN(lcw_tog),
    .NEXT_PAGE_REQUEST_OUT(npr), .MESSAGE_PAGE_FLAG_OUT(msg), .COMPLY_ACKNOWLEDGE_OUT(ack),
    .TOGGLE_OUT(tog), .CODE_OUT(code), .IRQ_OUT(irq));

  mgmt_master mgmt (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .rdata_in(rdata));

  // ---------------------------------------------------------------
  // Expectations and checking helpers
  // ---------------------------------------------------------------
  // Readback of the next page word: bit 14 zero, bit 11 from last toggle
  function automatic logic [15:0] npt_exp(input logic [15:0] w, input logic t);
    return {w[15], 1'b0, w[13:12], t, w[10:0]};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp, input string what);
    logic [15:0] v;
    mgmt.rd_reg(a, v);
    check(what, v, exp);
  endtask

  // One-cycle pulse on the selected event inputs
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    #1;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    ev = 4'h0;
    sd = 1'b0;
    lock = 1'b0;
    lcw_tog = 1'b0;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(519));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    // Reset values of fields and registers
    check("fields", {npr, 1'b0, msg, ack, tog, code}, 16'h2001);
    rdchk(ADR_NEXT_PAGE_TX, 16'h2001, "next page");
    rdchk(ADR_SUMMARY_STATUS, 16'h0000, "summary");
    // Writes of corner and random words, read-only toggle kept
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      mgmt.wr_reg(ADR_NEXT_PAGE_TX, d);
      check("fields", {npr, 1'b0, msg, ack, tog, code}, npt_exp(d, 1'b0));
      rdchk(ADR_NEXT_PAGE_TX, npt_exp(d, 1'b0), "next page");
      last_d = d;
    end
    // Reserved summary bits ignore writes
    mgmt.wr_reg(ADR_SUMMARY_STATUS, 16'hFFFF);
    rdchk(ADR_SUMMARY_STATUS, 16'h0000, "summary");
    // Toggle follows the inverse of each exchanged word
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      lcw_tog <= i[0];
      pulse(4'h4);
      check("toggle", {15'h0000, tog}, {15'h0000, ~i[0]});
      rdchk(ADR_NEXT_PAGE_TX, npt_exp(last_d, ~i[0]), "next page");
    end
    // Page received copy survives summary reads, cleared by expansion read
    rdchk(ADR_SUMMARY_STATUS, 16'h0100, "summary");
    rdchk(ADR_SUMMARY_STATUS, 16'h0100, "summary");
    rdchk(ADR_AUTONEG_EXP, 16'h0006, "expansion");
    rdchk(ADR_AUTONEG_EXP, 16'h0004, "expansion");
    rdchk(ADR_SUMMARY_STATUS, 16'h0000, "summary");
    // Error and code word events with a summary read in the very next cycle
    fork
      pulse(4'h5);
      begin
        @(posedge clk);
        rdchk(ADR_SUMMARY_STATUS, 16'h2100, "summary");
      end
    join
    rdchk(ADR_RX_ERROR_CNT, 16'h0000, "source");
    rdchk(ADR_AUTONEG_EXP, 16'h0006, "expansion");
    rdchk(ADR_SUMMARY_STATUS, 16'h0000, "summary");
    // Latched-high flags: kept over summary reads, cleared by their source read
    for (int k = 0; k < 3; k++) begin
      pulse(ev_tab[k]);
      rdchk(ADR_SUMMARY_STATUS, bit_tab[k], "summary");
      rdchk(ADR_SUMMARY_STATUS, bit_tab[k], "summary");
      rdchk(clr_tab[k], clrv_tab[k], "source");
      rdchk(ADR_SUMMARY_STATUS, 16'h0000, "summary");
    end
    // Latched-low detect and lock
    @(posedge clk);
    sd <= 1'b1;
    lock <= 1'b1;
    rdchk(ADR_SUMMARY_STATUS, 16'h0000, "summary");
    rdchk(ADR_SUMMARY_STATUS, 16'h0600, "summary");
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      if (j == 0) sd <= 1'b0;
      else lock <= 1'b0;
      @(posedge clk);
      sd <= 1'b1;
      lock <= 1'b1;
      rdchk(ADR_SUMMARY_STATUS, (j == 0) ? 16'h0200 : 16'h0400, "summary");
      rdchk(ADR_SUMMARY_STATUS, 16'h0600, "summary");
    end
    // Interrupts: clear, unmask, raise, mask, clear by read
    mgmt.rd_reg(ADR_IRQ_STATUS, d);
    mgmt.wr_reg(ADR_IRQ_MASK, 16'h001F);
    rdchk(ADR_IRQ_MASK, 16'h001F, "irq mask");
    check("irq", {15'h0000, irq}, 16'h0000);
    pulse(4'h1);
    check("irq", {15'h0000, irq}, 16'h0001);
    rdchk(ADR_IRQ_STATUS, 16'h0001, "irq status");
    check("irq", {15'h0000, irq}, 16'h0000);
    mgmt.wr_reg(ADR_IRQ_MASK, 16'h0000);
    pulse(4'h2);
    check("irq", {15'h0000, irq}, 16'h0000);
    mgmt.wr_reg(ADR_IRQ_MASK, 16'h0002);
    check("irq", {15'h0000, irq}, 16'h0001);
    rdchk(ADR_IRQ_STATUS, 16'h0002, "irq status");
    check("irq", {15'h0000, irq}, 16'h0000);
    rdchk(5'h1F, 16'h0000, "unmapped");
    // Reset in mid-run restores the null page
    mgmt.wr_reg(ADR_NEXT_PAGE_TX, 16'hFFFF);
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    #1;
    check("fields", {npr, 1'b0, msg, ack, tog, code}, 16'h2001);
    rdchk(ADR_NEXT_PAGE_TX, 16'h2001, "next page");
    end_sim();
  end
endmodule // next_page_status_regs_tb
